// *** bench/mtc_queue_model.sv ***
// Queue model that feeds frame bytes to the transmit engine
`timescale 1ns/100ps
module mtc_queue_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Bench control
    input wire logic qStart,
    input wire logic qAbort,
    input wire logic [7:0] qLen,
    input wire logic [7:0] qStarve,
    input wire logic [5:0] qId,
    // Engine side
    input wire logic inReady,
    input wire logic retryReq,
    input wire logic collision,
    output logic [7:0] inData,
    output logic inValid,
    output logic inLast,
    output logic [5:0] inFrameId
);
    logic [7:0] ptr; // Next byte index
    ////////////////////////////////////////////////////////////////
    // Pointer and valid; a retry replays from the first byte
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ptr <= 8'h00;
            inValid <= 1'b0;
        end else if (qStart || retryReq) begin
            ptr <= 8'h00;
            inValid <= 1'b1;
        end else if (qAbort || (collision && inReady)) begin
            inValid <= 1'b0;
        end else if (inValid && inReady) begin
            ptr <= ptr + 8'h01;
            inValid <= !(inLast || ptr + 8'h01 == qStarve);
        end
    end
    // Released data and id lines show the inverse and inLast stays low, so a stale byte never looks good
    assign inLast = inValid && ptr == qLen - 8'h01;
    assign inData = inValid ? ptr ^ 8'ha5 : ~(ptr ^ 8'ha5);
    assign inFrameId = inValid ? qId : ~qId;
endmodule

// *** bench/mtc_tx_checker.sv ***
// Port checker of the transmit control block
`timescale 1ns/100ps
module mtc_tx_checker #(
    parameter int RX_LEVEL_W = 11,
    parameter logic [10:0] PAUSE_THRESHOLD = 11'h600
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Watched ports
    input wire logic regRd,
    input wire logic [15:0] regRdData,
    input wire logic [7:0] inData,
    input wire logic inValid,
    input wire logic inReady,
    input wire logic retryReq,
    input wire logic [7:0] outData,
    input wire logic outValid,
    input wire logic outLast,
    input wire logic collision,
    input wire logic fullDuplex,
    input wire logic [RX_LEVEL_W-1:0] rxLevel,
    input wire logic pauseGrant,
    input wire logic pauseReq,
    input wire logic backPressure,
    input wire logic txRunning
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // Byte accepted with no collision pending
    sequence s_take;
        inReady && inValid && !collision;
    endsequence
    // Same byte on the link one cycle on
    sequence s_emit;
        outValid && outData == $past(inData);
    endsequence
    ////////////////////////////////////////////////////////////////
    a_rd_idle_zero: assert property (!$past(regRd) |-> regRdData == 16'h0000)
        else $error("read data not zero outside read cycle");
    a_byte_follows: assert property (s_take |=> s_emit)
        else $error("accepted byte not passed to link");
    a_last_valid: assert property (outLast |-> outValid)
        else $error("frame end without valid byte");
    a_gap_after_last: assert property (outLast |=> !outValid)
        else $error("no idle cycle between frames");
    a_ready_running: assert property (inReady |-> txRunning)
        else $error("bytes taken while stopped");
    a_retry_single: assert property (retryReq |=> !retryReq)
        else $error("retry request longer than one cycle");
    a_bp_half_only: assert property (backPressure |->
        !$past(fullDuplex) && $past(rxLevel) >= PAUSE_THRESHOLD)
        else $error("back-pressure without cause");
    a_pause_cross: assert property ($rose(pauseReq) |->
        $past(fullDuplex) && $past(rxLevel) >= PAUSE_THRESHOLD)
        else $error("pause request without cause");
    a_pause_half_off: assert property (!$past(fullDuplex) |-> !pauseReq)
        else $error("pause request in half duplex");
    a_grant_clears: assert property (pauseGrant |=> !pauseReq)
        else $error("pause request kept after grant");
endmodule

bind mtc_tx_control mtc_tx_checker #(
    .RX_LEVEL_W(RX_LEVEL_W),
    .PAUSE_THRESHOLD(PAUSE_THRESHOLD)
) mtc_tx_checker_i (.core_clk, .reset_n, .regRd, .regRdData, .inData, .inValid,
    .inReady, .retryReq, .outData, .outValid, .outLast, .collision, .fullDuplex,
    .rxLevel, .pauseGrant, .pauseReq, .backPressure, .txRunning);

// *** bench/testbench.sv ***
// Self-checking bench of the transmit control block
`timescale 1ns/100ps
module testbench;
    import mtc_pkg::*;
    localparam logic [10:0] TH = 11'h600;
    // Design ports
    logic core_clk, reset_n, regWr, regRd, irq, inValid, inLast, inReady, retryReq;
    logic queueRestart, outValid, outLast, collision, fullDuplex, pauseGrant;
    logic pauseReq, backPressure, txRunning;
    logic [7:0] regAddr, inData, outData;
    logic [15:0] regWrData, regRdData;
    logic [5:0] inFrameId;
    logic [10:0] rxLevel;
    // Queue model controls
    logic qStart, qAbort;
    logic [7:0] qLen, qStarve;
    logic [5:0] qId;
    int errCount, testsRun, nOut, nLast, cyc;
    logic [31:0] crcRun; // Running CRC of link bytes, residue checked

    mtc_tx_control #(.RX_LEVEL_W(11), .PAUSE_THRESHOLD(TH)) mtc_tx_control_i (.core_clk,
        .reset_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .irq, .inData,
        .inValid, .inLast, .inFrameId, .inReady, .retryReq, .queueRestart, .outData,
        .outValid, .outLast, .collision, .fullDuplex, .rxLevel, .pauseGrant,
        .pauseReq, .backPressure, .txRunning);
    mtc_queue_model mtc_queue_model_i (.core_clk, .reset_n, .qStart, .qAbort, .qLen,
        .qStarve, .qId, .inReady, .retryReq, .collision, .inData, .inValid, .inLast,
        .inFrameId);

    ////////////////////////////////////////////////////////////////
    // Clock, 8 ns period
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // Link byte counter and hang guard
    always @(posedge core_clk) begin
        cyc++;
        // whole frame with its CRC must leave the fixed residue
        if (outValid === 1'b1) begin
            nOut++;
            crcRun = crcRun ^ {24'h000000, outData};
            repeat (8) crcRun = crcRun[0] ? (crcRun >> 1) ^ CRC_POLY : crcRun >> 1;
        end
        if (outLast === 1'b1) nLast++;
        if (cyc == 40000) begin
            errCount++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        testsRun++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            errCount++;
        end
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task rd(input string what, input logic [7:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 chk(what, exp, regRdData);
    endtask
    // One frame; mode 1 clears run mid-frame, 2 late hit, 3 hit held, 4 no start
    task frame(input string what, input logic [15:0] ctl, input logic [7:0] len,
               input logic [7:0] stv, input int mode, input logic [15:0] sts,
               input int expN);
        int k;
        wr(TX_CONTROL_OFFSET, ctl);
        nOut = 0;
        nLast = 0;
        crcRun = CRC_PRESET;
        qLen <= len;
        qStarve <= stv;
        qId <= len[5:0];
        qStart <= 1'b1;
        collision <= (mode == 3);
        @(posedge core_clk);
        qStart <= 1'b0;
        k = 0;
        while (nOut < ((mode == 1) ? 5 : 66) && mode inside {1, 2} && k < 300) begin
            @(posedge core_clk);
            k++;
        end
        if (mode == 1) wr(TX_CONTROL_OFFSET, ctl & 16'hfffe);
        if (mode == 2) begin
            collision <= 1'b1;
            @(posedge core_clk);
            collision <= 1'b0;
        end
        k = 0;
        while (irq !== 1'b1 && k < 600) begin
            @(posedge core_clk);
            #1 k++;
        end
        @(posedge core_clk);
        collision <= 1'b0;
        repeat (3) @(posedge core_clk);
        qAbort <= 1'b1;
        @(posedge core_clk);
        qAbort <= 1'b0;
        if (expN >= 0) chk({what, " bytes"}, 16'(expN), 16'(nOut));
        if (expN > 0) chk({what, " ends"}, 16'h0001, 16'(nLast));
        if (expN > 0 && ctl[1]) chk({what, " crc"}, 16'h0001, 16'(crcRun == 32'hdebb20e3));
        if (mode != 4) begin
            rd({what, " status"}, TX_STATUS_OFFSET, sts | {10'h000, len[5:0]});
            #1 chk({what, " irq"}, 16'h0001, {15'h0000, irq});
            wr(INT_MASK_OFFSET, 16'h0000);
            #1 chk({what, " masked"}, 16'h0000, {15'h0000, irq});
            wr(INT_MASK_OFFSET, 16'h000f);
            #1 chk({what, " unmasked"}, 16'h0001, {15'h0000, irq});
            wr(INT_STATUS_OFFSET, 16'h000f);
            #1 chk({what, " cleared"}, 16'h0000, {15'h0000, irq});
        end
        $display("test %s done", what);
    endtask
    task end_sim();
        $display("checks %0d mismatches %0d", testsRun, errCount);
        if (errCount == 0 && testsRun > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {reset_n, regWr, regRd, queueRestart, collision, fullDuplex, pauseGrant} = '0;
        {qStart, qAbort, qLen, qStarve, qId, regAddr, regWrData, rxLevel} = '0;
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        rd("ctl reset", TX_CONTROL_OFFSET, 16'h0000);
        rd("sts reset", TX_STATUS_OFFSET, 16'h0000);
        wr(TX_CONTROL_OFFSET, 16'hffff);
        rd("ctl fields", TX_CONTROL_OFFSET, 16'h600f);
        wr(TX_STATUS_OFFSET, 16'hffff);
        rd("sts readonly", TX_STATUS_OFFSET, 16'h0000);
        wr(8'h0a, 16'hffff);
        rd("unmapped", 8'h0a, 16'h0000);
        wr(INT_MASK_OFFSET, 16'h000f);
        $display("test registers done");
        frame("plain", 16'h0001, 8'd70, 8'd0, 0, 16'h0000, 70);
        frame("pad crc", 16'h0007, 8'd10, 8'd0, 0, 16'h0000, 64);
        frame("pad only", 16'h0005, 8'd10, 8'd0, 0, 16'h0000, 64);
        frame("crc short", 16'h0003, 8'd10, 8'd0, 0, 16'h0000, 14);
        frame("bare short", 16'h0001, 8'd10, 8'd0, 0, 16'h0000, 10);
        frame("crc long", 16'h0003, 8'd70, 8'd0, 0, 16'h0000, 74);
        frame("stop mid", 16'h0001, 8'd100, 8'd0, 1, 16'h0000, 100);
        chk("stopped", 16'h0000, {15'h0000, txRunning});
        frame("held off", 16'h0000, 8'd20, 8'd0, 4, 16'h0000, 0);
        frame("late hit", 16'h0001, 8'd100, 8'd0, 2, 16'h2000, -1);
        frame("max hits", 16'h0001, 8'd20, 8'd0, 3, 16'h1000, -1);
        frame("underrun", 16'h0001, 8'd30, 8'd10, 0, 16'h4000, -1);
        frame("fatal", 16'h0001, 8'd30, 8'd0, 4, 16'h0000, 0);
        @(posedge core_clk);
        queueRestart <= 1'b1;
        @(posedge core_clk);
        queueRestart <= 1'b0;
        frame("restarted", 16'h0001, 8'd33, 8'd0, 0, 16'h0000, 33);
        // Flow control in every flag and duplex pairing
        for (int f = 0; f < 2; f++) begin
            for (int d = 0; d < 2; d++) begin
                wr(TX_CONTROL_OFFSET, 16'h0001 | 16'(f << 3));
                fullDuplex <= d[0];
                rxLevel <= TH;
                repeat (3) @(posedge core_clk);
                #1 chk("pause", 16'(f & d), {15'h0000, pauseReq});
                chk("backpressure", 16'(f & ~d & 1), {15'h0000, backPressure});
                @(posedge core_clk);
                pauseGrant <= 1'b1;
                rxLevel <= 11'h000;
                @(posedge core_clk);
                pauseGrant <= 1'b0;
                repeat (2) @(posedge core_clk);
                #1 chk("granted", 16'h0000, {15'h0000, pauseReq});
            end
        end
        $display("test flow done");
        end_sim();
    end
endmodule

// *** src/mtc_pkg.sv ***
// Shared constants of the transmit control and status block
package mtc_pkg;
    // Register offsets on the register port
    localparam logic [7:0] TX_CONTROL_OFFSET = 8'h00;
    localparam logic [7:0] TX_STATUS_OFFSET = 8'h02;
    localparam logic [7:0] INT_STATUS_OFFSET = 8'h04;
    localparam logic [7:0] INT_MASK_OFFSET = 8'h06;
    // Transmit control fields
    localparam int CTL_RUN_BIT = 0;
    localparam int CTL_CRC_BIT = 1;
    localparam int CTL_PAD_BIT = 2;
    localparam int CTL_FLOW_BIT = 3;
    localparam int CTL_SPARE_LO = 13;
    localparam int CTL_SPARE_HI = 14;
    localparam logic [15:0] CTL_RESET = 16'h0000;
    // Writable bits of transmit control; all others read as zero
    localparam logic [15:0] CTL_WRITE_MASK = 16'h600f;
    // Transmit status fields
    localparam int STS_ID_LO = 0;
    localparam int STS_ID_HI = 5;
    localparam int STS_MAXCOL_BIT = 12;
    localparam int STS_LATECOL_BIT = 13;
    localparam int STS_UNDERRUN_BIT = 14;
    localparam logic [15:0] STS_RESET = 16'h0000;
    // Interrupt status and mask layout
    localparam int INT_DONE_BIT = 0;
    localparam int INT_UNDERRUN_BIT = 1;
    localparam int INT_LATECOL_BIT = 2;
    localparam int INT_MAXCOL_BIT = 3;
    localparam int INT_BITS = 4;
    localparam logic [INT_BITS-1:0] INT_RESET = 4'h0;
    // Frame figures in bytes, and the attempt limit
    localparam logic [15:0] MIN_FRAME_BYTES = 16'h0040;
    localparam logic [15:0] CRC_BYTES = 16'h0004;
    localparam logic [15:0] LATE_COL_BYTES = 16'h0040;
    localparam logic [4:0] MAX_ATTEMPTS = 5'h10;
    // CRC-32 reflected polynomial and preset
    localparam logic [31:0] CRC_POLY = 32'hedb88320;
    localparam logic [31:0] CRC_PRESET = 32'hffffffff;
    // Transmit engine states
    typedef enum logic [2:0] {MTC_IDLE, MTC_DATA, MTC_PAD, MTC_CRC} mtc_state_t;
endpackage

// *** src/mtc_tx_control.sv ***
// Transmit control, framing and per-frame status of the MAC
//
// How it works
// R1: Full duplex flow enabled: request pause above threshold
// R2: Half duplex flow enabled: assert back-pressure instead
// R3: Flow bit clear: no pause, no back-pressure
// R4: Pad enabled: extend short frames to 64 bytes
// R5: Software pairs pad enable with CRC enable
// R6: CRC enabled: append CRC to every frame
// R7: Run bit set: engine may start queued frames
// R8: Run bit cleared: finish current frame, then stop
// R9: Status holds six-bit frame id of flags
// R10: Source running dry mid-frame sets underrun flag
// R11: Underrun is fatal until queue restart
// R12: Host feeds data faster than link drains
// R13: Collision after window sets late-collision flag
// R14: Reaching retry limit sets maximum-collision flag
// R15: Flags and id update together at completion
// R16: Reserved bits read zero, ignore writes
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
module mtc_tx_control #(
    parameter int RX_LEVEL_W = 11,
    parameter logic [10:0] PAUSE_THRESHOLD = 11'h600
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdData,
    // Interrupt
    output logic irq,
    // Frame byte stream from the queue
    input wire logic [7:0] inData,
    input wire logic inValid,
    input wire logic inLast,
    input wire logic [5:0] inFrameId,
    output logic inReady,
    output logic retryReq,
    // Queue management restart after a fatal underrun
    input wire logic queueRestart,
    // Byte stream to the link, one byte per cycle
    output logic [7:0] outData,
    output logic outValid,
    output logic outLast,
    // Link condition
    input wire logic collision,
    input wire logic fullDuplex,
    // Flow control
    input wire logic [RX_LEVEL_W-1:0] rxLevel,
    input wire logic pauseGrant,
    output logic pauseReq,
    output logic backPressure,
    // Engine state
    output logic txRunning
);
    import mtc_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    // Control and status registers
    logic [15:0] txControl, txStatus;
    logic [INT_BITS-1:0] intStatus, intMask;
    // Engine state and counters
    mtc_state_t state;
    logic [15:0] byteCount;
    logic [4:0] attempts;
    logic [31:0] crcReg;
    logic [1:0] crcIndex;
    logic [5:0] curId;
    // Fatal underrun latch
    logic fatal;
    // Completion strobe and its flags, formed combinationally
    logic finish, finUnderrun, finLate, finMax, retryNow;
    // Decoded control bits
    logic runEn, crcEn, padEn, flowEn;
    // Threshold state for pause edge detection
    logic aboveThr, aboveThrLast;
    // Pad target depends on whether the CRC fills the last four bytes
    logic [15:0] padTarget;
    // Collision classification
    logic inFrame, lateNow;
    assign runEn = txControl[CTL_RUN_BIT];
    assign crcEn = txControl[CTL_CRC_BIT];
    assign padEn = txControl[CTL_PAD_BIT];
    assign flowEn = txControl[CTL_FLOW_BIT];
    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    // One byte step of the reflected CRC-32
    function automatic logic [31:0] crc_byte(input logic [31:0] crc, input logic [7:0] data);
        logic [31:0] c;
        c = crc ^ {24'h000000, data};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // Register port
    // Control register; only documented and spare bits store
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            txControl <= CTL_RESET;
        end else if (regWr && regAddr == TX_CONTROL_OFFSET) begin
            // R16: reserved bits ignored
            txControl <= regWrData & CTL_WRITE_MASK;
        end
    end
    // Interrupt mask register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            intMask <= INT_RESET;
        end else if (regWr && regAddr == INT_MASK_OFFSET) begin
            intMask <= regWrData[INT_BITS-1:0];
        end
    end
    // Sticky interrupt bits; a new event beats a write-one clear
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            intStatus <= INT_RESET;
        end else begin
            logic [INT_BITS-1:0] events;
            logic [INT_BITS-1:0] clr;
            events = '0;
            clr = '0;
            events[INT_DONE_BIT] = finish;
            events[INT_UNDERRUN_BIT] = finish & finUnderrun;
            events[INT_LATECOL_BIT] = finish & finLate;
            events[INT_MAXCOL_BIT] = finish & finMax;
            if (regWr && regAddr == INT_STATUS_OFFSET) begin
                clr = regWrData[INT_BITS-1:0];
            end
            intStatus <= (intStatus & ~clr) | events;
        end
    end
    // Level interrupt from unmasked sticky bits
    assign irq = |(intStatus & intMask);
    // Read data stand one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            regRdData <= 16'h0000;
        end else if (regRd) begin
            unique case (regAddr)
                TX_CONTROL_OFFSET: regRdData <= txControl;
                TX_STATUS_OFFSET: regRdData <= txStatus;
                INT_STATUS_OFFSET: regRdData <= {12'h000, intStatus};
                INT_MASK_OFFSET: regRdData <= {12'h000, intMask};
                default: regRdData <= 16'h0000;
            endcase
        end else begin
            regRdData <= 16'h0000;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Flow control
    assign aboveThr = rxLevel >= PAUSE_THRESHOLD;
    // Pause request held until the sender grants it
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pauseReq <= 1'b0;
        end else if (!flowEn || !fullDuplex) begin
            // R3: no pause without flow bit
            pauseReq <= 1'b0;
        end else if (aboveThr && !aboveThrLast) begin
            // R1: pause near overflow
            pauseReq <= 1'b1;
        end else if (pauseGrant) begin
            pauseReq <= 1'b0;
        end
    end
    // Back-pressure in half duplex; the history arms one pause per crossing
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            aboveThrLast <= 1'b0;
            backPressure <= 1'b0;
        end else begin
            aboveThrLast <= aboveThr;
            // R2: half duplex back-pressure
            // R3: gated by flow bit
            backPressure <= flowEn && !fullDuplex && aboveThr;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Transmit engine
    // R4: pad to 64 including any CRC
    assign padTarget = crcEn ? (MIN_FRAME_BYTES - CRC_BYTES) : MIN_FRAME_BYTES;
    assign inFrame = state != MTC_IDLE;
    // R13: window measured in sent bytes
    assign lateNow = byteCount >= LATE_COL_BYTES;
    assign inReady = state == MTC_DATA;
    // Completion and its outcome, decided in the finishing cycle
    always_comb begin
        finish = 1'b0;
        finUnderrun = 1'b0;
        finLate = 1'b0;
        finMax = 1'b0;
        retryNow = 1'b0;
        if (inFrame && collision) begin
            if (lateNow) begin
                // R13: late collision ends frame
                finish = 1'b1;
                finLate = 1'b1;
            end else if (attempts + 5'h01 >= MAX_ATTEMPTS) begin
                // R14: retry limit reached
                finish = 1'b1;
                finMax = 1'b1;
            end else begin
                retryNow = 1'b1;
            end
        end else if (state == MTC_DATA && !inValid) begin
            // R10: source ran dry mid-frame
            finish = 1'b1;
            finUnderrun = 1'b1;
        end else if (state == MTC_DATA && inLast) begin
            finish = !(padEn && byteCount + 16'h0001 < padTarget) && !crcEn;
        end else if (state == MTC_PAD) begin
            finish = (byteCount + 16'h0001 >= padTarget) && !crcEn;
        end else if (state == MTC_CRC) begin
            finish = crcIndex == 2'h3;
        end
    end
    // State sequence of one frame
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= MTC_IDLE;
        end else if (finish || retryNow) begin
            state <= MTC_IDLE;
        end else begin
            unique case (state)
                MTC_IDLE: begin
                    // R7: start only when running
                    // R11: never while fatal
                    if (runEn && !fatal && inValid) begin
                        state <= MTC_DATA;
                    end
                end
                MTC_DATA: begin
                    if (inLast) begin
                        // R4: short frame goes to pad
                        if (padEn && byteCount + 16'h0001 < padTarget) begin
                            state <= MTC_PAD;
                        end else begin
                            state <= MTC_CRC;
                        end
                    end
                end
                MTC_PAD: begin
                    if (byteCount + 16'h0001 >= padTarget) begin
                        state <= MTC_CRC;
                    end
                end
                MTC_CRC: state <= MTC_CRC;
            endcase
        end
    end
    // Byte counter and frame id capture
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            byteCount <= 16'h0000;
            curId <= 6'h00;
        end else if (state == MTC_IDLE) begin
            byteCount <= 16'h0000;
            curId <= inFrameId;
        end else if (state != MTC_CRC) begin
            byteCount <= byteCount + 16'h0001;
        end
    end
    // Attempt count survives retries, clears on completion
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            attempts <= 5'h00;
        end else if (finish) begin
            attempts <= 5'h00;
        end else if (retryNow) begin
            attempts <= attempts + 5'h01;
        end
    end
    // Running CRC and its byte index while appending
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            crcReg <= CRC_PRESET;
            crcIndex <= 2'h0;
        end else if (state == MTC_IDLE) begin
            crcReg <= CRC_PRESET;
            crcIndex <= 2'h0;
        end else if (state == MTC_DATA && inValid) begin
            crcReg <= crc_byte(crcReg, inData);
        end else if (state == MTC_PAD) begin
            crcReg <= crc_byte(crcReg, 8'h00);
        end else if (state == MTC_CRC) begin
            crcReg <= {8'h00, crcReg[31:8]};
            crcIndex <= crcIndex + 2'h1;
        end
    end
    // Link byte output and replay request, registered
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            outData <= 8'h00;
            outValid <= 1'b0;
            outLast <= 1'b0;
            retryReq <= 1'b0;
        end else begin
            retryReq <= retryNow;
            outData <= 8'h00;
            outValid <= 1'b0;
            outLast <= 1'b0;
            if (!retryNow && !(finish && (finUnderrun || finLate || finMax))) begin
                unique case (state)
                    MTC_IDLE: outValid <= 1'b0;
                    MTC_DATA: begin
                        outData <= inData;
                        outValid <= 1'b1;
                        outLast <= finish;
                    end
                    MTC_PAD: begin
                        // R4: zero pad field
                        outValid <= 1'b1;
                        outLast <= finish;
                    end
                    MTC_CRC: begin
                        // R6: CRC appended, low byte first
                        outData <= ~crcReg[7:0];
                        outValid <= 1'b1;
                        outLast <= finish;
                    end
                endcase
            end
        end
    end
    // Fatal latch; restart clears it, but a new underrun wins
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            fatal <= 1'b0;
        end else if (finish && finUnderrun) begin
            // R11: underrun is fatal
            fatal <= 1'b1;
        end else if (queueRestart) begin
            fatal <= 1'b0;
        end
    end
    // Per-frame status record, written whole at completion
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            txStatus <= STS_RESET;
        end else if (finish) begin
            // R15: one consistent record
            // R9: flags belong to this id
            // R16: reserved bits stay zero
            txStatus <= STS_RESET;
            txStatus[STS_ID_HI:STS_ID_LO] <= curId;
            txStatus[STS_UNDERRUN_BIT] <= finUnderrun;
            txStatus[STS_LATECOL_BIT] <= finLate;
            txStatus[STS_MAXCOL_BIT] <= finMax;
        end
    end
    // Running indication follows the run bit only between frames
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            txRunning <= 1'b0;
        end else if (!inFrame || finish) begin
            // R8: stop after current frame
            txRunning <= runEn && !fatal;
        end else begin
            // R7: running while a frame is in flight
            txRunning <= 1'b1;
        end
    end
endmodule
